// >>> rtl/tfs_top.v
// Purpose: formatter enables, periodic sync counter, integration test regs
// Assumes: one clock pclk at 100 MHz, presetn async active low, apb slave
// Notes: pins trigin, flushin, atdata_s pass two flops before use
//
// Functional notes
// - trigger is byte 0x00 under id 0x7d
// - formatter and insertion enable bits change only while disabled
// - trigger insert on forces formatting on
// - formatter enable ignored in disabled state
// - unformatted only in circular buffer mode
// - sync period exponent resets to 0x0a
// - zero disables sync, else 2^value bytes
// - reserved exponent stored and used as 0x1b
// - new period loads at next zero
// - counter counts stored bytes during capture
// - counter zero issues sync request
// - embed set inserts frame sync at zero
// - embed only while formatting is active
// - unmapped offsets read zero, ignore writes
// - output test writes drive pins, read zero
// - master test bits map to master outputs
// - event test bits map to event outputs
// - input capture latches rises, clears on read
// - data capture maps bit0 and lane tops
// - data capture ignores writes, reads live
// - integration enable bit 0 enters test mode
// - trigger marks gated by per-condition enables
`include "tfs_regs.vh"

module tfs_top #(
  parameter DATA_W = 128,
  parameter CNT_W = 28
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // state of the surrounding controller
  input wire ctl_disabled,
  input wire capture_en,
  input wire circular_buffer_mode,
  // bytes stored into trace memory this cycle
  input wire [4:0] stored_bytes,
  // trigger causes from surrounding logic
  input wire flush_done_evt,
  input wire trig_evt,
  // pins from outside the clock domain
  input wire trigin,
  input wire flushin,
  input wire [DATA_W-1:0] atdata_s,
  // functional values of the test-driven outputs
  input wire func_atvalid_m,
  input wire func_afready_m,
  input wire func_atwakeup_m,
  input wire [3:0] func_atbytes_m,
  input wire func_acqcomp,
  input wire func_full,
  input wire func_flushcomp,
  input wire func_bufintr,
  // formatter control outputs
  output reg fmt_active,
  output reg trig_insert,
  output reg [6:0] trig_atid,
  output reg [7:0] trig_byte,
  output reg frame_sync_insert,
  output reg syncreq_s,
  // test-driven outputs
  output reg atvalid_m,
  output reg afready_m,
  output reg atwakeup_m,
  output reg [3:0] atbytes_m,
  output reg acqcomp,
  output reg full,
  output reg flushcomp,
  output reg bufintr
);

  localparam NTAP = 1 + DATA_W / 8;

  reg [10:0] fc_q;
  reg embed_q;
  reg [4:0] exp_q;
  reg [4:0] act_exp_q;
  reg [CNT_W-1:0] cnt_q;
  reg it_en_q;
  reg [11:0] mout_q;
  reg [3:0] evt_q;
  reg [1:0] cap_q;
  reg [1:0] tf_s1_q;
  reg [1:0] tf_s2_q;
  reg [1:0] tf_s3_q;
  reg [NTAP-1:0] dat_s1_q;
  reg [NTAP-1:0] dat_s2_q;
  reg [31:0] rdata_d;
  reg [4:0] exp_legal;
  reg fmt_d;
  reg zero_hit;
  wire [NTAP-1:0] taps;
  wire setup;
  wire wr_acc;
  wire rd_acc;
  wire [1:0] tf_rise;
  wire trig_cause;
  wire [CNT_W-1:0] bytes_w;
  wire [CNT_W-1:0] reload;

  // data capture taps: bit 0 then the top bit of each byte lane
  genvar gi;
  generate
    for (gi = 0; gi < NTAP; gi = gi + 1)
    begin : g_tap
      if (gi == 0)
      begin : g_lsb
        assign taps[gi] = atdata_s[0];
      end
      else
      begin : g_lane
        assign taps[gi] = atdata_s[8*gi-1];
      end
    end
  endgenerate

  // apb phases; answer always comes in the first access cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite & pready;

  // edges look only at settled stages, never at the first flop
  assign tf_rise = tf_s2_q & ~tf_s3_q;

  // any enabled trigger condition, blocked when insertion is off
  assign trig_cause = fc_q[`TFS_FC_TRIG_INS] &
    ((fc_q[`TFS_FC_TRIG_FL] & flush_done_evt) |
     (fc_q[`TFS_FC_TRIG_EVT] & trig_evt) |
     (fc_q[`TFS_FC_TRIG_IN] & tf_rise[0]));

  assign bytes_w = {{(CNT_W-5){1'b0}}, stored_bytes};
  // reload always takes the programmed exponent, so a new one lands at zero
  assign reload = {{(CNT_W-1){1'b0}}, 1'b1} << exp_q;

  // reserved exponents collapse onto the largest legal one
  always @*
  begin
    exp_legal = pwdata[4:0];
    if (pwdata[4:0] != 5'h00 &&
        (pwdata[4:0] < `TFS_PS_EXP_MIN ||
         pwdata[4:0] > `TFS_PS_EXP_MAX))
      exp_legal = `TFS_PS_EXP_MAX;
  end

  // effective formatting; enable bits only count outside disabled
  always @*
  begin
    fmt_d = 1'b0;
    if (!ctl_disabled)
      fmt_d = fc_q[`TFS_FC_FMT_EN] |
        fc_q[`TFS_FC_TRIG_INS] |
        ~circular_buffer_mode;
  end

  // counter meets zero when this cycle's bytes use up the rest
  always @*
  begin
    zero_hit = 1'b0;
    if (capture_en && act_exp_q != 5'h00 && cnt_q <= bytes_w)
      zero_hit = 1'b1;
  end

  // read mux, decoded in setup so prdata comes from a flop
  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `TFS_OFS_FMT_CTRL:
        rdata_d = {21'h000000, fc_q};
      `TFS_OFS_PSYNC:
        rdata_d = {26'h0000000, embed_q, exp_q};
      `TFS_OFS_IT_CTRL:
        rdata_d = {31'h00000000, it_en_q};
      `TFS_OFS_TRFL_CAP:
        if (it_en_q)
          rdata_d = {30'h00000000, cap_q};
      `TFS_OFS_DATA_CAP:
        if (it_en_q)
          rdata_d[NTAP-1:0] = dat_s2_q;
      default:
        rdata_d = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait-free access, never an error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup && !pwrite)
        prdata <= rdata_d;
    end
  end

  // two-flop synchronisers for every pin, third stage for edges
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tf_s1_q <= 2'b00;
      tf_s2_q <= 2'b00;
      tf_s3_q <= 2'b00;
      dat_s1_q <= {NTAP{1'b0}};
      dat_s2_q <= {NTAP{1'b0}};
    end
    else
    begin
      tf_s1_q <= {flushin, trigin};
      tf_s2_q <= tf_s1_q;
      tf_s3_q <= tf_s2_q;
      dat_s1_q <= taps;
      dat_s2_q <= dat_s1_q;
    end
  end

  // control registers written by software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fc_q <= `TFS_FC_RESET;
      embed_q <= 1'b0;
      exp_q <= `TFS_PS_EXP_RESET;
      it_en_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      case (paddr)
        `TFS_OFS_FMT_CTRL:
        begin
          fc_q[10:2] <= pwdata[10:2];
          if (ctl_disabled)
            fc_q[1:0] <= pwdata[1:0];
        end
        `TFS_OFS_PSYNC:
        begin
          embed_q <= pwdata[`TFS_PS_EMBED];
          exp_q <= exp_legal;
        end
        `TFS_OFS_IT_CTRL:
          it_en_q <= pwdata[`TFS_IT_EN];
        default:
          it_en_q <= it_en_q;
      endcase
    end
  end

  // write-only output test registers, written only in integration mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mout_q <= 12'h000;
      evt_q <= 4'h0;
    end
    else if (wr_acc && it_en_q)
    begin
      if (paddr == `TFS_OFS_MOUT_DRV)
        mout_q <= {pwdata[11:8], 5'h00, pwdata[2:0]};
      if (paddr == `TFS_OFS_EVT_DRV)
        evt_q <= pwdata[3:0];
    end
  end

  // input capture: rises latch, a read clears, the rise wins
  // a read clears only what it returned, so a rise at setup is kept
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_q <= 2'b00;
    else if (!it_en_q)
      cap_q <= 2'b00;
    else if (rd_acc && paddr == `TFS_OFS_TRFL_CAP)
      cap_q <= (cap_q & ~prdata[1:0]) | tf_rise;
    else
      cap_q <= cap_q | tf_rise;
  end

  // periodic sync counter over stored bytes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_exp_q <= `TFS_PS_EXP_RESET;
      cnt_q <= {{(CNT_W-11){1'b0}}, 11'h400};
    end
    else if (!capture_en || act_exp_q == 5'h00)
    begin
      // idle: stays armed with the programmed period
      act_exp_q <= exp_q;
      cnt_q <= reload;
    end
    else if (zero_hit)
    begin
      act_exp_q <= exp_q;
      cnt_q <= reload;
    end
    else
      cnt_q <= cnt_q - bytes_w;
  end

  // stream markers and formatting state; fmt_active is a level, not a pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_active <= 1'b0;
      trig_insert <= 1'b0;
      trig_atid <= 7'h00;
      trig_byte <= 8'h00;
      frame_sync_insert <= 1'b0;
      syncreq_s <= 1'b0;
    end
    else
    begin
      fmt_active <= fmt_d;
      trig_insert <= capture_en & trig_cause;
      trig_atid <= `TFS_TRIG_ID;
      trig_byte <= `TFS_TRIG_BYTE;
      syncreq_s <= zero_hit;
      frame_sync_insert <= zero_hit & embed_q & fmt_d;
    end
  end

  // test-driven outputs: register value in integration mode
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      atvalid_m <= 1'b0;
      afready_m <= 1'b0;
      atwakeup_m <= 1'b0;
      atbytes_m <= 4'h0;
      acqcomp <= 1'b0;
      full <= 1'b0;
      flushcomp <= 1'b0;
      bufintr <= 1'b0;
    end
    else if (it_en_q)
    begin
      atvalid_m <= mout_q[0];
      afready_m <= mout_q[1];
      atwakeup_m <= mout_q[2];
      atbytes_m <= mout_q[11:8];
      acqcomp <= evt_q[0];
      full <= evt_q[1];
      flushcomp <= evt_q[2];
      bufintr <= evt_q[3];
    end
    else
    begin
      atvalid_m <= func_atvalid_m;
      afready_m <= func_afready_m;
      atwakeup_m <= func_atwakeup_m;
      atbytes_m <= func_atbytes_m;
      acqcomp <= func_acqcomp;
      full <= func_full;
      flushcomp <= func_flushcomp;
      bufintr <= func_bufintr;
    end
  end

endmodule // tfs_top

// >>> common/tfs_regs.vh
// Purpose: register map and constants of the trace formatter sync block
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes: definitions only
`ifndef TFS_REGS_VH
`define TFS_REGS_VH

// register byte offsets
`define TFS_OFS_FMT_CTRL 12'h304
`define TFS_OFS_PSYNC 12'h308
`define TFS_OFS_MOUT_DRV 12'hedc
`define TFS_OFS_EVT_DRV 12'hee0
`define TFS_OFS_TRFL_CAP 12'hee8
`define TFS_OFS_DATA_CAP 12'heec
`define TFS_OFS_IT_CTRL 12'hf00

// formatter_flush_control fields
`define TFS_FC_FMT_EN 0
`define TFS_FC_TRIG_INS 1
`define TFS_FC_TRIG_IN 8
`define TFS_FC_TRIG_EVT 9
`define TFS_FC_TRIG_FL 10
`define TFS_FC_RESET 11'h000

// periodic_sync_control fields
`define TFS_PS_EMBED 5
`define TFS_PS_EXP_RESET 5'h0a
`define TFS_PS_EXP_MIN 5'h07
`define TFS_PS_EXP_MAX 5'h1b

// integration_mode_control and capture fields
`define TFS_IT_EN 0
`define TFS_CAP_TRIGIN 0
`define TFS_CAP_FLUSHIN 1

// trigger marker inserted in the stream
`define TFS_TRIG_ID 7'h7d
`define TFS_TRIG_BYTE 8'h00

`endif

// >>> sim/tfs_chk.sv
// Purpose: port assertions for tfs_top
// Assumes: one clock pclk, presetn async active low
// Notes: bound into every tfs_top
module tfs_chk (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb answer
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // capture state
  input wire capture_en,
  // stream control
  input wire fmt_active,
  input wire trig_insert,
  input wire [6:0] trig_atid,
  input wire [7:0] trig_byte,
  input wire frame_sync_insert,
  input wire syncreq_s
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // slave answers one cycle after setup, for one cycle
  a_apb_answer:
    assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse:
    assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready too long");
  a_no_slverr:
    assert property (!pslverr) else $error("slverr set");
  // marker fields must be valid whenever a trigger is inserted
  a_trig_mark:
    assert property (trig_insert |-> trig_atid == 7'h7d
      && trig_byte == 8'h00) else $error("bad trigger marker");
  a_trig_capture:
    assert property (trig_insert |-> $past(capture_en))
      else $error("trigger without capture");
  // at most 16 bytes a cycle, so periods are 8 cycles or more
  a_sync_idle:
    assert property (syncreq_s |-> $past(capture_en))
      else $error("sync while idle");
  a_sync_space:
    assert property (syncreq_s |=> !syncreq_s [*7])
      else $error("sync period short");
  a_fsync_gate:
    assert property (frame_sync_insert |-> syncreq_s && fmt_active)
      else $error("frame sync misplaced");
endmodule // tfs_chk

bind tfs_top tfs_chk tfs_chk_i (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .capture_en, .fmt_active, .trig_insert, .trig_atid, .trig_byte,
  .frame_sync_insert, .syncreq_s);

// >>> sim/tfs_sink.sv
// Purpose: trace memory side storing one full beat a cycle
// Assumes: 128-bit beats from a single source
// Notes: full beats keep sync periods short
module tfs_sink (
  // capture control
  input wire capture_en,
  // bytes stored this cycle
  output wire [4:0] stored_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  // sixteen bytes while capture runs, none otherwise
  assign stored_bytes = capture_en ? 5'h10 : 5'h00;
endmodule // tfs_sink

// >>> sim/tb_tfs_top.sv
// Purpose: directed apb tests of tfs_top
// Assumes: pclk 100 MHz, presetn low for 12 cycles
// Notes: sync periods use the exponents 0x07 and 0x08
`include "tfs_regs.vh"
module tb_tfs_top;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, all set at time zero
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ctl_disabled = 1'b1, capture_en = 1'b0;
  logic circular_buffer_mode = 1'b1, trig_evt = 1'b0;
  logic trigin = 1'b0, flushin = 1'b0, flush_done_evt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [127:0] atdata_s = 128'h0;
  logic [10:0] fv = 11'h000;
  logic [5:0] wv [6] = '{6'h03, 6'h1c, 6'h00, 6'h07, 6'h06, 6'h3f};
  logic [5:0] ev [6] = '{6'h1b, 6'h1b, 6'h00, 6'h07, 6'h1b, 6'h3b};
  // outputs
  wire [31:0] prdata;
  wire [6:0] trig_atid;
  wire [7:0] trig_byte;
  wire [4:0] stored_bytes;
  wire [3:0] atbytes_m;
  wire pready, pslverr, fmt_active, trig_insert, frame_sync_insert, syncreq_s;
  wire atvalid_m, afready_m, atwakeup_m, acqcomp, full, flushcomp, bufintr;
  int err_count = 0, n_checks = 0, cyc = 0, last = 0;
  // clock and a cycle stamp for period checks
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  tfs_sink tfs_sink_i (.capture_en, .stored_bytes);
  tfs_top tfs_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ctl_disabled, .capture_en,
    .circular_buffer_mode, .stored_bytes, .flush_done_evt, .trig_evt,
    .trigin, .flushin, .atdata_s, .func_atvalid_m(fv[0]),
    .func_afready_m(fv[1]), .func_atwakeup_m(fv[2]),
    .func_atbytes_m(fv[6:3]), .func_acqcomp(fv[7]), .func_full(fv[8]),
    .func_flushcomp(fv[9]), .func_bufintr(fv[10]), .fmt_active, .trig_insert,
    .trig_atid, .trig_byte, .frame_sync_insert, .syncreq_s, .atvalid_m,
    .afready_m, .atwakeup_m, .atbytes_m, .acqcomp, .full, .flushcomp, .bufintr);
  task automatic final_report;
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; idle edge first so psel never changes twice at once
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // waits for the next sync pulse and checks cycles since the last
  task automatic nxt(input int exp);
    @(posedge pclk);
    while (syncreq_s !== 1'b1) @(posedge pclk);
    if (exp > 0) check(cyc - last, exp);
    last = cyc;
  endtask
  // pulses one trigger cause (flush done or trigger event), watches marker
  task automatic trg(input logic fl, input logic [31:0] e);
    logic h;
    h = 1'b0;
    trig_evt <= ~fl;
    flush_done_evt <= fl;
    @(posedge pclk);
    trig_evt <= 1'b0;
    flush_done_evt <= 1'b0;
    repeat (4)
    begin
      @(posedge pclk);
      h = h | trig_insert;
      if (trig_insert)
        check({trig_atid, trig_byte}, 32'h7d00);
    end
    check(h, e);
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200us;
    err_count++;
    final_report;
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`TFS_OFS_PSYNC, 32'h0000000a);
    for (int i = 0; i < 6; i++)
    begin
      wr(`TFS_OFS_PSYNC, {26'h0, wv[i]});
      rdc(`TFS_OFS_PSYNC, {26'h0, ev[i]});
    end
    wr(12'h100, 32'hffffffff);
    rdc(12'h100, 32'h0);
    ctl_disabled <= 1'b0;
    wr(`TFS_OFS_FMT_CTRL, 32'h203);
    rdc(`TFS_OFS_FMT_CTRL, 32'h200);
    ctl_disabled <= 1'b1;
    wr(`TFS_OFS_FMT_CTRL, 32'h202);
    rdc(`TFS_OFS_FMT_CTRL, 32'h202);
    ctl_disabled <= 1'b0;
    capture_en <= 1'b1;
    repeat (2) @(posedge pclk);
    check(fmt_active, 1'b1);
    trg(1'b0, 32'h1);
    trg(1'b1, 32'h0);
    ctl_disabled <= 1'b1;
    wr(`TFS_OFS_FMT_CTRL, 32'h200);
    ctl_disabled <= 1'b0;
    repeat (2) @(posedge pclk);
    check(fmt_active, 1'b0);
    trg(1'b0, 32'h0);
    circular_buffer_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    check(fmt_active, 1'b1);
    circular_buffer_mode <= 1'b1;
    // new period lands at zero or while idle, so restart capture
    capture_en <= 1'b0;
    wr(`TFS_OFS_PSYNC, 32'h27);
    @(posedge pclk);
    capture_en <= 1'b1;
    nxt(0);
    check(frame_sync_insert, 1'b0);
    ctl_disabled <= 1'b1;
    wr(`TFS_OFS_FMT_CTRL, 32'h1);
    ctl_disabled <= 1'b0;
    nxt(0);
    nxt(8);
    check(frame_sync_insert, 1'b1);
    wr(`TFS_OFS_PSYNC, 32'h28);
    nxt(8);
    nxt(16);
    capture_en <= 1'b0;
    wr(`TFS_OFS_MOUT_DRV, 32'hf07);
    wr(`TFS_OFS_IT_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    check({atbytes_m, atwakeup_m, afready_m, atvalid_m}, 7'h00);
    wr(`TFS_OFS_MOUT_DRV, 32'hf07);
    repeat (2) @(posedge pclk);
    check({atbytes_m, atwakeup_m, afready_m, atvalid_m}, 7'h7f);
    rdc(`TFS_OFS_MOUT_DRV, 32'h0);
    wr(`TFS_OFS_EVT_DRV, 32'ha);
    repeat (2) @(posedge pclk);
    check({bufintr, flushcomp, full, acqcomp}, 4'ha);
    rdc(`TFS_OFS_EVT_DRV, 32'h0);
    atdata_s <= {1'b1, 119'h0, 8'hc1};
    wr(`TFS_OFS_DATA_CAP, 32'hffff);
    rdc(`TFS_OFS_DATA_CAP, 32'h10003);
    trigin <= 1'b1;
    repeat (5) @(posedge pclk);
    rdc(`TFS_OFS_TRFL_CAP, 32'h1);
    rdc(`TFS_OFS_TRFL_CAP, 32'h0);
    flushin <= 1'b1;
    repeat (5) @(posedge pclk);
    wr(`TFS_OFS_IT_CTRL, 32'h0);
    wr(`TFS_OFS_IT_CTRL, 32'h1);
    rdc(`TFS_OFS_TRFL_CAP, 32'h0);
    wr(`TFS_OFS_IT_CTRL, 32'h0);
    fv <= 11'h5a3;
    rdc(`TFS_OFS_DATA_CAP, 32'h0);
    check({bufintr, flushcomp, full, acqcomp, atbytes_m, atwakeup_m,
      afready_m, atvalid_m}, 11'h5a3);
    final_report;
  end
endmodule // tb_tfs_top
